// >>> core/sfs_cfg.svh
// constants for the sanitize freeze and status block
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH
`define SFS_CMD_SANITIZE   8'hB4
`define SFS_FEAT_STATUS    16'h0000
`define SFS_FEAT_FREEZE    16'h0020
`define SFS_FEAT_OVERWRITE 16'h0014
`define SFS_KEY_LBA        48'h0000_4672_4C6B
`define SFS_RSN_NONE       8'h00
`define SFS_RSN_UNSAN      8'h01
`define SFS_RSN_BADFEAT    8'h02
`define SFS_RSN_FROZEN     8'h03
`define SFS_PROG_IDLE      16'hFFFF
`define SFS_CNT_DONE_BIT   15
`define SFS_CNT_BUSY_BIT   14
`define SFS_CNT_FRZ_BIT    13
`define SFS_CLR_FAIL_BIT   0
`define SFS_FMODE_BIT      4
`define SFS_ERR_ABT_BIT    2
`define SFS_ST_RDY_BIT     6
`define SFS_ST_DSC_BIT     4
`define SFS_ST_ERR_BIT     0
`endif

// >>> core/sfs_pkg.sv
// types for the sanitize freeze and status block
package sfs_pkg;
	typedef enum logic [4:0] {
		SFS_IDLE   = 5'b0_0001,
		SFS_FROZEN = 5'b0_0010,
		SFS_OPER   = 5'b0_0100,
		SFS_FAILED = 5'b0_1000,
		SFS_DONE   = 5'b1_0000
	} sfs_state_type;
endpackage

// >>> core/sfs_decode.sv
// feature-code decoder for the sanitize command
`include "sfs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sfs_decode (
	input  wire logic [7:0]  command,
	input  wire logic [15:0] feature,
	input  wire logic [47:0] lba,
	output logic             is_status,
	output logic             is_freeze,
	output logic             key_ok,
	output logic             is_unknown
);
	// feature code picks sub-command
	// pure decode; lba carries the freeze key
	always_comb begin
		is_status  = (command == `SFS_CMD_SANITIZE) &&
			(feature == `SFS_FEAT_STATUS);
		is_freeze  = (command == `SFS_CMD_SANITIZE) &&
			(feature == `SFS_FEAT_FREEZE);
		// key lives in the low four address bytes only
		key_ok     = (lba[31:0] == 32'(`SFS_KEY_LBA));
		is_unknown = (command == `SFS_CMD_SANITIZE) && !is_status &&
			!is_freeze;
	end
endmodule // sfs_decode
`default_nettype wire

// >>> core/sfs_progress.sv
// progress value selection for the status answer
`include "sfs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sfs_progress (
	input  wire logic        in_oper,
	input  wire logic [15:0] oper_progress,
	output logic [15:0]      progress
);
	// all ones unless an operation is running
	always_comb begin
		progress = in_oper ? oper_progress : `SFS_PROG_IDLE;
	end
endmodule // sfs_progress
`default_nettype wire

// >>> core/sfs_core.sv
// sanitize freeze-lock and status command interpreter
`include "sfs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sfs_core (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        por_n,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  command,
	input  wire logic [15:0] feature,
	input  wire logic [15:0] sector_count,
	input  wire logic [47:0] lba,
	input  wire logic        oper_start,
	input  wire logic        oper_fmode,
	input  wire logic        oper_end,
	input  wire logic        oper_fail,
	input  wire logic [15:0] oper_progress,
	output logic             cmd_done,
	output logic [7:0]       command_error_flags,
	output logic [7:0]       command_status_flags,
	output logic [15:0]      ret_count,
	output logic [7:0]       ret_sector_number,
	output logic [7:0]       ret_cyl_low,
	output logic             frozen
);
	sfs_pkg::sfs_state_type state_q, state_d;
	logic        done_q, done_d;
	logic        fmode_q, fmode_d;
	logic        bad_cmd_q, bad_cmd_d;
	logic        cmd_done_q, cmd_done_d;
	logic [7:0]  err_q, err_d, st_q, st_d;
	logic [15:0] cnt_q, cnt_d;
	logic [7:0]  sn_q, sn_d, cl_q, cl_d;
	logic        is_status, is_freeze, key_ok, is_unknown;
	logic [15:0] progress;

	sfs_decode u_dec (
		.command    (command),
		.feature    (feature),
		.lba        (lba),
		.is_status  (is_status),
		.is_freeze  (is_freeze),
		.key_ok     (key_ok),
		.is_unknown (is_unknown)
	);

	sfs_progress u_prog (
		.in_oper       (state_q == sfs_pkg::SFS_OPER),
		.oper_progress (oper_progress),
		.progress      (progress)
	);

	// abort helper: error flags with only the abort bit set
	function automatic logic [7:0] abt_flags();
		return 8'h04;
	endfunction

	// next-state and answer computation
	always_comb begin
		state_d   = state_q;
		done_d    = done_q;
		fmode_d   = fmode_q;
		bad_cmd_d = bad_cmd_q;
		cmd_done_d = 1'b0;
		err_d     = err_q;
		st_d      = st_q;
		cnt_d     = cnt_q;
		sn_d      = sn_q;
		cl_d      = cl_q;
		// background operation lifecycle from the media engine
		case (state_q)
		sfs_pkg::SFS_IDLE, sfs_pkg::SFS_FAILED, sfs_pkg::SFS_DONE: begin
			if (oper_start) begin
				state_d = sfs_pkg::SFS_OPER;
				fmode_d = oper_fmode;
				done_d  = 1'b0;
			end
		end
		sfs_pkg::SFS_OPER: begin
			if (oper_end) begin
				state_d = oper_fail ? sfs_pkg::SFS_FAILED
					: sfs_pkg::SFS_DONE;
				done_d  = !oper_fail;
			end
		end
		sfs_pkg::SFS_FROZEN: begin
			state_d = sfs_pkg::SFS_FROZEN;
		end
		default: state_d = sfs_pkg::SFS_IDLE;
		endcase
		// flag frozen while power is lost
		if (!por_n)
			done_d = done_q;
		if (cmd_valid && command == `SFS_CMD_SANITIZE) begin
			cmd_done_d = 1'b1;
			// busy clear, ready and seek complete set
			st_d = 8'h00;
			st_d[`SFS_ST_RDY_BIT] = 1'b1;
			st_d[`SFS_ST_DSC_BIT] = 1'b1;
			err_d = 8'h00;
			cnt_d = 16'h0000;
			sn_d  = `SFS_RSN_NONE;
			cl_d  = 8'h00;
			bad_cmd_d = 1'b0;
			if (is_status) begin
				cnt_d[`SFS_CNT_DONE_BIT] = done_d;
				cnt_d[`SFS_CNT_BUSY_BIT] = (state_q == sfs_pkg::SFS_OPER);
				cnt_d[`SFS_CNT_FRZ_BIT]  = (state_q == sfs_pkg::SFS_FROZEN);
				// 16-bit numerator split over two bytes
				cl_d = progress[15:8];
				sn_d = progress[7:0];
				if (bad_cmd_q)
					sn_d = `SFS_RSN_BADFEAT;
				if (sector_count[`SFS_CLR_FAIL_BIT] &&
					state_q == sfs_pkg::SFS_FAILED) begin
					if (fmode_q) begin
						state_d = sfs_pkg::SFS_IDLE;
					end else begin
						err_d = abt_flags();
						st_d[`SFS_ST_ERR_BIT] = 1'b1;
						sn_d = `SFS_RSN_UNSAN;
					end
				end
			end else if (state_q == sfs_pkg::SFS_FROZEN) begin
				err_d = abt_flags();
				st_d[`SFS_ST_ERR_BIT] = 1'b1;
				sn_d = `SFS_RSN_FROZEN;
			end else if (is_freeze && key_ok &&
				state_q != sfs_pkg::SFS_OPER) begin
				state_d = sfs_pkg::SFS_FROZEN;
			end else begin
				err_d = abt_flags();
				st_d[`SFS_ST_ERR_BIT] = 1'b1;
				sn_d = `SFS_RSN_BADFEAT;
				bad_cmd_d = is_unknown;
			end
		end
	end

	// state registers; done flag is not reset here
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q    <= sfs_pkg::SFS_IDLE;
			fmode_q    <= 1'b0;
			bad_cmd_q  <= 1'b0;
			cmd_done_q <= 1'b0;
			err_q      <= 8'h00;
			st_q       <= 8'h50;
			cnt_q      <= 16'h0000;
			sn_q       <= 8'h00;
			cl_q       <= 8'h00;
		end else begin
			state_q    <= state_d;
			fmode_q    <= fmode_d;
			bad_cmd_q  <= bad_cmd_d;
			cmd_done_q <= cmd_done_d;
			err_q      <= err_d;
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			sn_q       <= sn_d;
			cl_q       <= cl_d;
		end
	end

	// done flag survives resets; backed by retained storage
	always_ff @(posedge ref_clk) begin
		done_q <= done_d;
	end

	assign cmd_done             = cmd_done_q;
	assign command_error_flags  = err_q;
	assign command_status_flags = st_q;
	assign ret_count            = cnt_q;
	assign ret_sector_number    = sn_q;
	assign ret_cyl_low          = cl_q;
	assign frozen               = (state_q == sfs_pkg::SFS_FROZEN);

	// all checks share the one clock and sleep while reset is held
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_FREEZE_ENTERS: assert property (
		cmd_valid && is_freeze && key_ok && command == `SFS_CMD_SANITIZE
		&& state_q == sfs_pkg::SFS_IDLE |=> frozen)
		else $error("freeze did not enter frozen");
	AST_FROZEN_STAYS: assert property (
		frozen |=> frozen) else $error("left frozen without reset");
	AST_FROZEN_ABORT: assert property (
		cmd_valid && command == `SFS_CMD_SANITIZE && !is_status && frozen
		|=> err_q[`SFS_ERR_ABT_BIT] && sn_q == `SFS_RSN_FROZEN)
		else $error("frozen did not abort");
	AST_STATUS_OK: assert property (
		cmd_valid && is_status && !sector_count[0] |=>
		!st_q[`SFS_ST_ERR_BIT] && cmd_done)
		else $error("status query refused");
	AST_PROG_IDLE: assert property (
		cmd_valid && is_status && state_q != sfs_pkg::SFS_OPER
		&& !bad_cmd_q && !(sector_count[0] && !fmode_q &&
		state_q == sfs_pkg::SFS_FAILED) |=> {cl_q, sn_q} == `SFS_PROG_IDLE)
		else $error("progress not all ones");
	AST_FRZ_BIT: assert property (
		cmd_valid && is_status && frozen |=> cnt_q[`SFS_CNT_FRZ_BIT])
		else $error("frozen bit missing");
	AST_BUSY_BIT: assert property (
		cmd_valid && is_status && state_q == sfs_pkg::SFS_OPER
		&& !oper_end |=> cnt_q[`SFS_CNT_BUSY_BIT])
		else $error("busy bit missing");
	AST_CLR_FAIL: assert property (
		cmd_valid && is_status && sector_count[0] && fmode_q &&
		state_q == sfs_pkg::SFS_FAILED |=> state_q == sfs_pkg::SFS_IDLE)
		else $error("clear failure did not go idle");
	AST_CLR_ABORT: assert property (
		cmd_valid && is_status && sector_count[0] && !fmode_q &&
		state_q == sfs_pkg::SFS_FAILED |=> st_q[`SFS_ST_ERR_BIT])
		else $error("clear failure not aborted");
	AST_BAD_KEY: assert property (
		cmd_valid && is_freeze && !key_ok && !frozen &&
		command == `SFS_CMD_SANITIZE |=> sn_q == `SFS_RSN_BADFEAT)
		else $error("bad key not refused");

	// freeze is refused while an operation runs
	AST_FREEZE_OPER: assert property (
		cmd_valid && is_freeze && state_q == sfs_pkg::SFS_OPER |=> !frozen)
		else $error("froze during an operation");
	// status query is never refused when frozen
	AST_STATUS_FROZEN: assert property (
		cmd_valid && is_status && frozen |=> !st_q[`SFS_ST_ERR_BIT])
		else $error("status refused while frozen");

	// retained completion flag: set, cleared and held
	AST_DONE_SET: assert property (
		state_q == sfs_pkg::SFS_OPER && oper_end && !oper_fail && por_n
		|=> done_q)
		else $error("done flag not set on success");
	AST_DONE_CLR: assert property (
		state_q != sfs_pkg::SFS_OPER && !frozen && oper_start && por_n
		|=> !done_q)
		else $error("done flag not cleared on start");
	AST_DONE_HOLD: assert property (
		!por_n |=> $stable(done_q))
		else $error("done flag moved while power was lost");

	// progress and busy bit follow the operation state
	AST_PROG_OPER: assert property (
		cmd_valid && is_status && state_q == sfs_pkg::SFS_OPER
		&& !bad_cmd_q |=> {cl_q, sn_q} == $past(oper_progress))
		else $error("progress not passed through");
	AST_BUSY_CLR: assert property (
		cmd_valid && is_status && state_q != sfs_pkg::SFS_OPER
		|=> !cnt_q[`SFS_CNT_BUSY_BIT])
		else $error("busy bit set outside operation");

	// reason codes and error flags of refused commands
	AST_BAD_FEAT: assert property (
		cmd_valid && is_unknown && !frozen
		|=> err_q[`SFS_ERR_ABT_BIT] && sn_q == `SFS_RSN_BADFEAT)
		else $error("unknown feature not refused");
	AST_CLR_REASON: assert property (
		cmd_valid && is_status && sector_count[0] && !fmode_q &&
		state_q == sfs_pkg::SFS_FAILED |=> sn_q == `SFS_RSN_UNSAN)
		else $error("clear failure abort without reason");
	AST_ERR_ABORT: assert property (
		st_q[`SFS_ST_ERR_BIT] |-> err_q[`SFS_ERR_ABT_BIT] && !st_q[7])
		else $error("error without abort or with busy");

	// every sanitize command is answered next cycle
	AST_CMD_DONE: assert property (
		cmd_valid && command == `SFS_CMD_SANITIZE |=> cmd_done)
		else $error("sanitize command not answered");

	// main scenarios reached
	COV_FREEZE: cover property (cmd_valid && is_freeze ##1 frozen);
	COV_STATUS: cover property (cmd_valid && is_status ##1 cmd_done);
	COV_CLEAR: cover property (state_q == sfs_pkg::SFS_FAILED ##1
		state_q == sfs_pkg::SFS_IDLE);
	COV_FAIL_ABORT: cover property (state_q == sfs_pkg::SFS_FAILED &&
		cmd_valid && is_status ##1 st_q[`SFS_ST_ERR_BIT]);
	COV_BAD_FEAT: cover property (cmd_valid && is_unknown ##1
		err_q[`SFS_ERR_ABT_BIT]);
endmodule // sfs_core
`default_nettype wire

// >>> verification/sfs_host.sv
// host controller model issuing sanitize commands
`timescale 1ns/1ps
`default_nettype none
module sfs_host (
	input  wire logic   ref_clk,
	input  wire logic   cmd_done,
	output logic        cmd_valid,
	output logic [7:0]  command,
	output logic [15:0] feature,
	output logic [15:0] sector_count,
	output logic [47:0] lba
);
	logic seen = 1'b0;
	// idle bus before the first command
	initial begin
		cmd_valid = 1'b0;
		command = 8'h00;
		feature = 16'hFFFF;
		sector_count = 16'h0000;
		lba = 48'h0000_0000_0000;
	end
	// fields held with the strobe; scrambled once taken, so stale
	// values can never pass for live ones
	// feature selects sub-command
	task automatic issue(input logic [15:0] f, sc, input logic [47:0] a);
		@(posedge ref_clk) #1;
		cmd_valid = 1'b1;
		command = 8'hB4;
		feature = f;
		sector_count = sc;
		lba = a;
		@(posedge ref_clk) #1;
		seen = cmd_done;
		cmd_valid = 1'b0;
		command = 8'h4B;
		feature = ~f;
		sector_count = ~sc;
		lba = ~a;
	endtask
endmodule // sfs_host
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the sanitize freeze and status block
`timescale 1ns/1ps
`default_nettype none
`include "sfs_cfg.svh"
module tb;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        por_n = 1'b1;
	logic        oper_start = 1'b0;
	logic        oper_fmode = 1'b0;
	logic        oper_end = 1'b0;
	logic        oper_fail = 1'b0;
	logic [15:0] oper_progress = 16'h1234;
	logic        cmd_valid, cmd_done, frozen;
	logic [7:0]  command, command_error_flags, command_status_flags;
	logic [7:0]  ret_sector_number, ret_cyl_low;
	logic [15:0] feature, sector_count, ret_count;
	logic [47:0] lba;
	int          bad_count = 0;
	int          checks = 0;
	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;
	sfs_host HOST (.ref_clk, .cmd_done, .cmd_valid, .command, .feature,
		.sector_count, .lba);
	sfs_core DUT (.ref_clk, .rst, .por_n, .cmd_valid, .command, .feature,
		.sector_count, .lba, .oper_start, .oper_fmode, .oper_end,
		.oper_fail, .oper_progress, .cmd_done, .command_error_flags,
		.command_status_flags, .ret_count, .ret_sector_number,
		.ret_cyl_low, .frozen);
	task automatic complete_run;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, s);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// hardware reset: the retained done flag must survive it
	task automatic rst_pulse(input int n);
		@(posedge ref_clk) #1;
		rst = 1'b1;
		repeat (n) @(posedge ref_clk);
		#1 rst = 1'b0;
	endtask
	// media engine event, one cycle wide
	task automatic eng(input logic s, e, fm, fl);
		@(posedge ref_clk) #1;
		oper_start = s;
		oper_end = e;
		oper_fmode = fm;
		oper_fail = fl;
		@(posedge ref_clk) #1;
		oper_start = 1'b0;
		oper_end = 1'b0;
	endtask
	// judge flags and sector number of the last answer
	task automatic res(input logic [7:0] er, st, sn);
		chk("cmd_done", 16'h0001, {15'h0000, HOST.seen});
		chk("error_flags", {8'h00, er}, {8'h00, command_error_flags});
		chk("status_flags", {8'h00, st}, {8'h00, command_status_flags});
		chk("sector_number", {8'h00, sn}, {8'h00, ret_sector_number});
	endtask
	// status query judging count flags and progress
	task automatic sts(input logic [15:0] sc, input logic [2:0] cb,
		input logic [15:0] p);
		HOST.issue(16'h0000, sc, 48'h0000_0000_0000);
		chk("count_flags", {cb, 13'h0000}, ret_count);
		chk("progress", p, {ret_cyl_low, ret_sector_number});
	endtask
	task automatic t_idle;
		HOST.issue(16'h0000, 16'h0000, 48'h0000_0000_0000);
		res(8'h00, 8'h50, 8'hFF);
		chk("busy_frz", 16'h0000, {14'h0000, ret_count[14:13]});
		chk("prog_hi", 16'h00FF, {8'h00, ret_cyl_low});
	endtask
	task automatic t_oper;
		eng(1'b1, 1'b0, 1'b1, 1'b0);
		sts(16'h0000, 3'b010, 16'h1234);
		eng(1'b0, 1'b1, 1'b1, 1'b1);
		sts(16'h0000, 3'b000, 16'hFFFF);
		sts(16'h0001, 3'b000, 16'hFFFF);
		res(8'h00, 8'h50, 8'hFF);
	endtask
	task automatic t_done;
		eng(1'b1, 1'b0, 1'b1, 1'b0);
		eng(1'b0, 1'b1, 1'b1, 1'b0);
		sts(16'h0000, 3'b100, 16'hFFFF);
		rst_pulse(1);
		sts(16'h0000, 3'b100, 16'hFFFF);
		// power lost across a start and a reset: flag must hold
		por_n = 1'b0;
		eng(1'b1, 1'b0, 1'b1, 1'b0);
		rst_pulse(1);
		por_n = 1'b1;
		sts(16'h0000, 3'b100, 16'hFFFF);
	endtask
	task automatic t_fail0;
		eng(1'b1, 1'b0, 1'b0, 1'b0);
		sts(16'h0000, 3'b010, 16'h1234);
		eng(1'b0, 1'b1, 1'b0, 1'b1);
		HOST.issue(16'h0000, 16'h0001, 48'h0000_0000_0000);
		res(8'h04, 8'h51, 8'h01);
		rst_pulse(1);
	endtask
	task automatic t_bad;
		HOST.issue(16'h0077, 16'h0000, 48'h0000_0000_0000);
		res(8'h04, 8'h51, 8'h02);
		HOST.issue(16'h0000, 16'h0000, 48'h0000_0000_0000);
		res(8'h00, 8'h50, 8'h02);
		HOST.issue(16'h0020, 16'h0000, 48'h0000_0000_0000);
		res(8'h04, 8'h51, 8'h02);
		chk("frozen", 16'h0000, {15'h0000, frozen});
	endtask
	task automatic t_frz;
		HOST.issue(16'h0020, 16'h0000, `SFS_KEY_LBA);
		chk("frozen", 16'h0001, {15'h0000, frozen});
		sts(16'h0000, 3'b001, 16'hFFFF);
		HOST.issue(16'h0020, 16'h0000, `SFS_KEY_LBA);
		res(8'h04, 8'h51, 8'h03);
		rst_pulse(1);
		chk("frozen", 16'h0000, {15'h0000, frozen});
	endtask
	// main sequence
	initial begin
		rst_pulse(5);
		t_idle;
		t_oper;
		t_done;
		t_fail0;
		t_bad;
		t_frz;
		complete_run;
	end
	// watchdog, far beyond the few dozen cycles needed
	initial begin
		#(25 * 1000);
		bad_count++;
		complete_run;
	end
endmodule // tb
`default_nettype wire
